// [lsa_cfg.svh]
// constants for the light sensor measurement core
`ifndef LSA_CFG_SVH
`define LSA_CFG_SVH

// register offsets
`define LSA_ADDR_CMD        3'h0
`define LSA_ADDR_CTL        3'h1
`define LSA_ADDR_THR_HI     3'h2
`define LSA_ADDR_THR_LO     3'h3
`define LSA_ADDR_RES_LO     3'h4
`define LSA_ADDR_RES_HI     3'h5
`define LSA_ADDR_TMR_LO     3'h6
`define LSA_ADDR_TMR_HI     3'h7

// special address bits of a write
`define LSA_ABIT_RESTART    7
`define LSA_ABIT_CLR_INT    6

// command register fields
`define LSA_CMD_ENABLE      7
`define LSA_CMD_PWRDN       6
`define LSA_CMD_HOST_TIMED  5
`define LSA_CMD_SEL_HI      3
`define LSA_CMD_SEL_LO      2
`define LSA_CMD_WID_HI      1
`define LSA_CMD_WID_LO      0

// control register fields
`define LSA_CTL_FLAG        5
`define LSA_CTL_GAIN_HI     3
`define LSA_CTL_GAIN_LO     2
`define LSA_CTL_PER_HI      1
`define LSA_CTL_PER_LO      0

// reset values
`define LSA_RST_CMD         8'h00
`define LSA_RST_CTL         8'h00
`define LSA_RST_THR_HI      8'hff
`define LSA_RST_THR_LO      8'h00

// oscillator cycles per conversion
`define LSA_TICKS_W0        17'h10000
`define LSA_TICKS_W1        17'h01000
`define LSA_TICKS_W2        17'h00100
`define LSA_TICKS_W3        17'h00010

// full-scale masks of an n-bit result
`define LSA_MASK_W0         16'hffff
`define LSA_MASK_W1         16'h0fff
`define LSA_MASK_W2         16'h00ff
`define LSA_MASK_W3         16'h000f

// persistence counts
`define LSA_PERSIST_P0      5'h01
`define LSA_PERSIST_P1      5'h04
`define LSA_PERSIST_P2      5'h08
`define LSA_PERSIST_P3      5'h10

// oscillator timing: fast period in ns, core clock period in ns
`define LSA_OSC_FAST_PERIOD_NS  1527
`define LSA_CLK_PERIOD_NS       100
`define LSA_OSC_FAST_DIV        (`LSA_OSC_FAST_PERIOD_NS / `LSA_CLK_PERIOD_NS)
`define LSA_OSC_SLOW_DIV        (2 * `LSA_OSC_FAST_DIV)

`endif

// [lsa_pkg.sv]
// types shared by the light sensor measurement core
`default_nettype none

package lsa_pkg;

	typedef logic [7:0] lsa_byte_t;

	typedef enum logic [1:0] {
		LSA_IDLE,
		LSA_INT_A,
		LSA_INT_B
	} lsa_state_e;

endpackage : lsa_pkg

`default_nettype wire

// [lsa_osc.sv]
// conversion oscillator tick generator with dual speed
`timescale 1ns/1ps
`default_nettype none
`include "lsa_cfg.svh"

module lsa_osc (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic run,
	input  wire logic slow,
	output logic      tick
);

	logic [4:0] div_q;
	logic [4:0] div_d;
	logic [4:0] last;

	////////////////////////////////////////////////////////////////////////////
	// divider; slow ranges wait twice as long between ticks
	always_comb
	begin
		last  = slow ? 5'(`LSA_OSC_SLOW_DIV - 1) : 5'(`LSA_OSC_FAST_DIV - 1);
		tick  = run && (div_q >= last);
		div_d = div_q + 5'h01;
		if (!run || tick)
		begin
			div_d = 5'h00; // stopped oscillator restarts phase-aligned
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			div_q <= 5'h00;
		end
		else
		begin
			div_q <= div_d;
		end
	end

endmodule : lsa_osc
`default_nettype wire

// [lsa_persist.sv]
// consecutive out-of-window result filter
`timescale 1ns/1ps
`default_nettype none
`include "lsa_cfg.svh"

module lsa_persist (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       clear,
	input  wire logic       result_valid,
	input  wire logic       out_window,
	input  wire logic [1:0] persist_sel,
	output logic            hit
);

	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [4:0] need;
	logic [4:0] cnt_inc;

	////////////////////////////////////////////////////////////////////////////
	// count saturates at 16 so a long excursion keeps firing
	always_comb
	begin
		case (persist_sel)
			2'h0:    need = `LSA_PERSIST_P0;
			2'h1:    need = `LSA_PERSIST_P1;
			2'h2:    need = `LSA_PERSIST_P2;
			default: need = `LSA_PERSIST_P3;
		endcase
		cnt_inc = (cnt_q == `LSA_PERSIST_P3) ? cnt_q : cnt_q + 5'h01;
		cnt_d   = cnt_q;
		hit     = 1'b0;
		if (clear)
		begin
			cnt_d = 5'h00;
		end
		else if (result_valid)
		begin
			if (out_window)
			begin
				cnt_d = cnt_inc;
				hit   = (cnt_inc >= need);
			end
			else
			begin
				cnt_d = 5'h00;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cnt_q <= 5'h00;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end

endmodule : lsa_persist
`default_nettype wire

// [lsa_core.sv]
// light sensor measurement core: registers, integration, threshold interrupt
`timescale 1ns/1ps
`default_nettype none
`include "lsa_cfg.svh"

module lsa_core (
	input  wire logic       core_clk,
	input  wire logic       reset,
	// register port, as delivered by the serial slave
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// analog front end
	input  wire logic       photodiode_a_pulse,
	input  wire logic       photodiode_b_pulse,
	output logic      [1:0] photodiode_route,
	output logic      [1:0] front_end_gain,
	output logic            device_power_down,
	output logic            adc_run,
	// interrupt pin
	output logic            int_n
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	lsa_pkg::lsa_byte_t  cmd_q, cmd_d;
	lsa_pkg::lsa_byte_t  ctl_q, ctl_d;
	lsa_pkg::lsa_byte_t  thr_hi_q, thr_hi_d;
	lsa_pkg::lsa_byte_t  thr_lo_q, thr_lo_d;
	lsa_pkg::lsa_byte_t  rdata_q, rdata_d;
	lsa_pkg::lsa_state_e st_q, st_d;
	logic [16:0]         ticks_q, ticks_d;
	logic [16:0]         acc_q, acc_d;
	logic [16:0]         acc_a_q, acc_a_d;
	logic [15:0]         timer_q, timer_d;
	logic [15:0]         result_q, result_d;
	logic [15:0]         timer_cap_q, timer_cap_d;
	logic                flag_q, flag_d;

	logic                plain_wr;
	logic                restart;
	logic                clr_int;
	logic                enable;
	logic                host_timed;
	logic [1:0]          sel;
	logic [1:0]          width;
	logic                run;
	logic                tick;
	logic                pulse;
	logic [16:0]         ticks_nx;
	logic [16:0]         acc_nx;
	logic [15:0]         timer_nx;
	logic [16:0]         need_ticks;
	logic [15:0]         full_mask;
	logic                phase_end;
	logic                result_valid;
	logic [15:0]         result_nx;
	logic signed [17:0]  diff;
	logic signed [17:0]  pos_lim;
	logic signed [17:0]  neg_lim;
	logic                out_window;
	logic                hit;

	////////////////////////////////////////////////////////////////////////////
	// address decode: the top two address bits are strobes, not registers

	assign restart  = reg_wr && reg_addr[`LSA_ABIT_RESTART];
	assign clr_int  = reg_wr && reg_addr[`LSA_ABIT_CLR_INT];
	assign plain_wr = reg_wr && (reg_addr[7:3] == 5'h00);

	// command fields
	assign enable     = cmd_q[`LSA_CMD_ENABLE];
	assign host_timed = cmd_q[`LSA_CMD_HOST_TIMED];
	assign sel        = cmd_q[`LSA_CMD_SEL_HI:`LSA_CMD_SEL_LO];
	assign width      = cmd_q[`LSA_CMD_WID_HI:`LSA_CMD_WID_LO];

	// converter runs only when enabled, powered and given a real mode
	assign run = enable && !cmd_q[`LSA_CMD_PWRDN] && (sel != 2'h3);

	////////////////////////////////////////////////////////////////////////////
	// front end steering

	assign device_power_down = cmd_q[`LSA_CMD_PWRDN];
	assign adc_run           = run;
	assign front_end_gain    = ctl_q[`LSA_CTL_GAIN_HI:`LSA_CTL_GAIN_LO];
	assign int_n             = !flag_q;
	assign reg_rdata         = rdata_q;

	// route follows the phase; difference mode takes diode a then diode b
	always_comb
	begin
		photodiode_route = 2'h0;
		if (st_q == lsa_pkg::LSA_INT_A)
		begin
			photodiode_route = (sel == 2'h1) ? 2'h2 : 2'h1;
		end
		else if (st_q == lsa_pkg::LSA_INT_B)
		begin
			photodiode_route = 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// oscillator and persistence filter

	lsa_osc u_osc (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (run),
		.slow     (!front_end_gain[1]),
		.tick     (tick)
	);

	lsa_persist u_persist (
		.core_clk     (core_clk),
		.reset        (reset),
		.clear        (!run),
		.result_valid (result_valid),
		.out_window   (out_window),
		.persist_sel  (ctl_q[`LSA_CTL_PER_HI:`LSA_CTL_PER_LO]),
		.hit          (hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// width lookup: conversion length and full-scale code

	always_comb
	begin
		case (width)
			2'h0:
			begin
				need_ticks = `LSA_TICKS_W0;
				full_mask  = `LSA_MASK_W0;
			end
			2'h1:
			begin
				need_ticks = `LSA_TICKS_W1;
				full_mask  = `LSA_MASK_W1;
			end
			2'h2:
			begin
				need_ticks = `LSA_TICKS_W2;
				full_mask  = `LSA_MASK_W2;
			end
			default:
			begin
				need_ticks = `LSA_TICKS_W3;
				full_mask  = `LSA_MASK_W3;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// per-tick accumulation and end-of-phase detection

	always_comb
	begin
		pulse    = (photodiode_route == 2'h2) ? photodiode_b_pulse : photodiode_a_pulse;
		ticks_nx = ticks_q + {16'h0000, tick};
		acc_nx   = acc_q + {16'h0000, tick && pulse};
		timer_nx = timer_q + {15'h0000, tick};
		if (host_timed)
		begin
			phase_end = restart;
		end
		else
		begin
			phase_end = (ticks_nx == need_ticks);
		end
	end

	// result shaping: unsigned clamp, or signed n-bit difference
	always_comb
	begin
		pos_lim = $signed({2'h0, 1'b0, full_mask[15:1]});
		neg_lim = -pos_lim - 18'sd1;
		diff    = $signed({1'b0, acc_a_q}) - $signed({1'b0, acc_nx});
		if (sel == 2'h2)
		begin
			if (diff > pos_lim)
			begin
				result_nx = pos_lim[15:0];
			end
			else if (diff < neg_lim)
			begin
				result_nx = neg_lim[15:0];
			end
			else
			begin
				result_nx = diff[15:0];
			end
		end
		else if (acc_nx > {1'b0, full_mask})
		begin
			result_nx = full_mask;
		end
		else
		begin
			result_nx = acc_nx[15:0];
		end
	end

	// window test on the fresh result; lower byte of each bound is zero
	assign out_window = (result_nx > {thr_hi_q, 8'h00})
		|| (result_nx < {thr_lo_q, 8'h00});

	////////////////////////////////////////////////////////////////////////////
	// integration sequencer

	always_comb
	begin
		st_d         = st_q;
		ticks_d      = ticks_nx;
		acc_d        = acc_nx;
		acc_a_d      = acc_a_q;
		timer_d      = timer_nx;
		result_d     = result_q;
		timer_cap_d  = timer_cap_q;
		result_valid = 1'b0;
		if (!run)
		begin
			// disabled converter sits in reset; results stay readable
			st_d    = lsa_pkg::LSA_IDLE;
			ticks_d = 17'h00000;
			acc_d   = 17'h00000;
			acc_a_d = 17'h00000;
			timer_d = 16'h0000;
		end
		else
		begin
			case (st_q)
				lsa_pkg::LSA_IDLE:
				begin
					st_d    = lsa_pkg::LSA_INT_A;
					ticks_d = 17'h00000;
					acc_d   = 17'h00000;
					timer_d = 16'h0000;
				end
				lsa_pkg::LSA_INT_A,
				lsa_pkg::LSA_INT_B:
				begin
					if (phase_end && (st_q == lsa_pkg::LSA_INT_A) && (sel == 2'h2))
					begin
						// first half of a difference conversion
						st_d    = lsa_pkg::LSA_INT_B;
						acc_a_d = acc_nx;
						acc_d   = 17'h00000;
						ticks_d = 17'h00000;
					end
					else if (phase_end)
					begin
						st_d         = lsa_pkg::LSA_INT_A;
						result_d     = result_nx;
						timer_cap_d  = timer_nx;
						result_valid = 1'b1;
						ticks_d      = 17'h00000;
						acc_d        = 17'h00000;
						timer_d      = 16'h0000;
					end
				end
				default:
				begin
					st_d = lsa_pkg::LSA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_q        <= lsa_pkg::LSA_IDLE;
			ticks_q     <= 17'h00000;
			acc_q       <= 17'h00000;
			acc_a_q     <= 17'h00000;
			timer_q     <= 16'h0000;
			result_q    <= 16'h0000;
			timer_cap_q <= 16'h0000;
		end
		else
		begin
			st_q        <= st_d;
			ticks_q     <= ticks_d;
			acc_q       <= acc_d;
			acc_a_q     <= acc_a_d;
			timer_q     <= timer_d;
			result_q    <= result_d;
			timer_cap_q <= timer_cap_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers and interrupt flag

	// a new trigger in the clearing cycle wins so no event is lost
	always_comb
	begin
		cmd_d    = cmd_q;
		ctl_d    = ctl_q;
		thr_hi_d = thr_hi_q;
		thr_lo_d = thr_lo_q;
		flag_d   = hit || (flag_q && !clr_int);
		if (plain_wr)
		begin
			case (reg_addr[2:0])
				`LSA_ADDR_CMD:    cmd_d    = reg_wdata & 8'hef; // reserved bit 4 kept zero
				`LSA_ADDR_CTL:    ctl_d    = reg_wdata & 8'h0f; // factory bits and flag not writable
				`LSA_ADDR_THR_HI: thr_hi_d = reg_wdata;
				`LSA_ADDR_THR_LO: thr_lo_d = reg_wdata;
				default:          cmd_d    = cmd_q; // result and timer bytes are read-only
			endcase
		end
	end

	// read data is captured on the read strobe and held
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd)
		begin
			rdata_d = 8'h00; // unmapped addresses read zero
			if (reg_addr[7:3] == 5'h00)
			begin
				case (reg_addr[2:0])
					`LSA_ADDR_CMD:    rdata_d = cmd_q;
					`LSA_ADDR_CTL:    rdata_d = ctl_q | {2'h0, flag_q, 5'h00};
					`LSA_ADDR_THR_HI: rdata_d = thr_hi_q;
					`LSA_ADDR_THR_LO: rdata_d = thr_lo_q;
					`LSA_ADDR_RES_LO: rdata_d = result_q[7:0];
					`LSA_ADDR_RES_HI: rdata_d = result_q[15:8];
					`LSA_ADDR_TMR_LO: rdata_d = timer_cap_q[7:0];
					default:          rdata_d = timer_cap_q[15:8];
				endcase
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cmd_q    <= `LSA_RST_CMD;
			ctl_q    <= `LSA_RST_CTL;
			thr_hi_q <= `LSA_RST_THR_HI;
			thr_lo_q <= `LSA_RST_THR_LO;
			flag_q   <= 1'b0;
			rdata_q  <= 8'h00;
		end
		else
		begin
			cmd_q    <= cmd_d;
			ctl_q    <= ctl_d;
			thr_hi_q <= thr_hi_d;
			thr_lo_q <= thr_lo_d;
			flag_q   <= flag_d;
			rdata_q  <= rdata_d;
		end
	end

endmodule : lsa_core
`default_nettype wire

// [lsa_core_props.sv]
// port assertions for the light sensor measurement core
`timescale 1ns/1ps
`default_nettype none

module lsa_core_props (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] photodiode_route,
	input wire logic [1:0] front_end_gain,
	input wire logic       device_power_down,
	input wire logic       adc_run,
	input wire logic       int_n
);
	logic [7:0] cmd_q;
	logic [7:0] ctl_q;
	logic [7:0] hi_q;
	logic [7:0] lo_q;
	logic       clr;

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// clear strobe rides on address bit 6 of any write
	assign clr = reg_wr && reg_addr[6];

	// shadow copies of the writable fields, strobe addresses store nothing
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cmd_q <= 8'h00;
			ctl_q <= 8'h00;
			hi_q  <= 8'hff;
			lo_q  <= 8'h00;
		end
		else if (reg_wr && reg_addr[7:3] == 5'h00)
		begin
			if (reg_addr[2:0] == 3'h0)
				cmd_q <= reg_wdata & 8'hef;
			if (reg_addr[2:0] == 3'h1)
				ctl_q <= reg_wdata & 8'h0f;
			if (reg_addr[2:0] == 3'h2)
				hi_q <= reg_wdata;
			if (reg_addr[2:0] == 3'h3)
				lo_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	a_run_follows_cmd: assert property (adc_run == (cmd_q[7] && !cmd_q[6] && cmd_q[3:2] != 2'h3))
		else $error("converter run does not follow command");
	a_pd_follows_cmd: assert property (device_power_down == cmd_q[6])
		else $error("power down does not follow command");
	a_gain_follows_ctl: assert property (front_end_gain == ctl_q[3:2])
		else $error("gain does not follow control");
	a_idle_no_route: assert property (!adc_run [*2] |-> photodiode_route == 2'h0)
		else $error("diode routed while converter idle");
	a_single_route: assert property ((cmd_q[3:2] == 2'h0) [*2] |-> photodiode_route != 2'h2)
		else $error("second diode routed in first diode mode");
	a_int_holds: assert property (!int_n && !clr |=> !int_n)
		else $error("interrupt released without clear");
	a_int_rise_cause: assert property ($rose(int_n) |-> $past(clr))
		else $error("interrupt rose without clear write");
	a_thr_readback: assert property (reg_rd && reg_addr[7:1] == 7'h01 |=>
		reg_rdata == ($past(reg_addr[0]) ? $past(lo_q) : $past(hi_q)))
		else $error("threshold read back wrong");
	a_ctl_readback: assert property (reg_rd && reg_addr == 8'h01 |=>
		reg_rdata == {2'h0, !$past(int_n), 1'h0, $past(ctl_q[3:0])})
		else $error("control read back wrong");
	a_cmd_readback: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(cmd_q))
		else $error("command read back wrong");
endmodule : lsa_core_props

bind lsa_core lsa_core_props u_props (
	.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.photodiode_route(photodiode_route), .front_end_gain(front_end_gain),
	.device_power_down(device_power_down), .adc_run(adc_run), .int_n(int_n)
);

`default_nettype wire

// [lsa_host_model.sv]
// host side model driving the register port
`timescale 1ns/1ps
`default_nettype none

module lsa_host_model (
	input  wire logic       core_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// quiet bus from time zero
	initial
	begin
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// one access, taken at one edge; released lines show inverted junk
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge core_clk);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
		q = reg_rdata;
	endtask : access

	// strobe ending one host-timed integration and starting the next
	task automatic restart();
		logic [7:0] q;
		access(1'h1, 8'h80, 8'h00, q);
	endtask : restart

	// stop the converter first, power down in a later write
	task automatic shutdown();
		logic [7:0] q;
		access(1'h1, 8'h00, 8'h00, q);
		access(1'h1, 8'h00, 8'h40, q);
	endtask : shutdown
endmodule : lsa_host_model

`default_nettype wire

// [tb.sv]
// self-checking bench for the light sensor measurement core
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("MISMATCH %s expected %h seen %h", nm, e, g); \
		end \
	end

module tb;
	logic       core_clk;
	logic       reset;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       pa;
	logic       pb;
	logic [1:0] route;
	logic [1:0] gain;
	logic       pd;
	logic       run;
	logic       int_n;
	logic [7:0] q;
	logic [15:0] r;
	logic [15:0] res;
	int         bad_count;
	int         tests_run;
	int         seed;
	int         n;
	int         e;

	lsa_core i_lsa_core (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.photodiode_a_pulse(pa), .photodiode_b_pulse(pb), .photodiode_route(route),
		.front_end_gain(gain), .device_power_down(pd), .adc_run(run), .int_n(int_n));
	lsa_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// 10 MHz core clock
	always #50 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////
	// result of a 16 tick conversion with steady diode pulses
	function automatic logic [15:0] exp_res(input int s, input logic a, input logic b);
		if (s == 0)
			return a ? 16'h000f : 16'h0000;
		if (s == 1)
			return b ? 16'h000f : 16'h0000;
		return (a && !b) ? 16'h0007 : ((!a && b) ? 16'hfff8 : 16'h0000);
	endfunction : exp_res

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.access(1'h1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
		u_host.access(1'h0, a, 8'h00, q);
		`CHK("register read", x, q)
	endtask : rd_chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// bounded wait for the interrupt pin to go low
	task automatic wait_int();
		n = 0;
		while (int_n !== 1'h0 && n < 5000)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 5000)
		begin
			bad_count++;
			$display("MISMATCH interrupt wait expected 0 seen %h", int_n);
			close_out();
		end
	endtask : wait_int

	////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'h0;
		reset = 1'h1;
		{pa, pb} = 2'h0;
		seed = 42878;
		bad_count = 0;
		tests_run = 0;
		repeat (4) @(posedge core_clk);
		#1;
		reset = 1'h0;
		for (int i = 0; i < 8; i++)
			rd_chk(8'(i), (i == 2) ? 8'hff : 8'h00);
		// random thresholds, masked and read-only places, unmapped address
		for (int i = 2; i < 4; i++)
		begin
			r = 16'($random(seed));
			wr(8'(i), r[7:0]);
			rd_chk(8'(i), r[7:0]);
		end
		wr(8'h00, 8'h1f);
		rd_chk(8'h00, 8'h0f);
		wr(8'h01, 8'hff);
		rd_chk(8'h01, 8'h0f);
		wr(8'h04, 8'h55);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h0a, 8'h00);
		// internally timed conversions, width 16 ticks, fast range
		wr(8'h01, 8'h0c);
		wr(8'h02, 8'hff);
		wr(8'h03, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			{pa, pb} = 2'($random(seed));
			r = exp_res(k % 3, pa, pb);
			wr(8'h00, {4'h8, 2'(k % 3), 2'h3});
			repeat ((k % 3 == 2) ? 600 : 300) @(posedge core_clk);
			wr(8'h00, 8'h00);
			rd_chk(8'h04, r[7:0]);
			rd_chk(8'h05, r[15:8]);
			if (k % 3 != 2)
				rd_chk(8'h06, 8'h10);
		end
		{pa, pb} = 2'h3;
		wr(8'h00, 8'h8f);
		repeat (300) @(posedge core_clk);
		rd_chk(8'h04, r[7:0]);
		// 256 tick width: unsigned clamp to 8 bits, timer holds the tick count
		{pa, pb} = 2'h2;
		wr(8'h00, 8'h82);
		repeat (3900) @(posedge core_clk);
		wr(8'h00, 8'h00);
		rd_chk(8'h04, 8'hff);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h07, 8'h01);
		// persistence and range speed from enable to interrupt
		wr(8'h02, 8'h00);
		{pa, pb} = 2'h2;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h00, 8'h00);
			wr(8'h40, 8'h00);
			wr(8'h01, {4'h0, 2'(k), 2'(k)});
			wr(8'h00, 8'h83);
			wait_int();
			e = ((k == 0) ? 1 : (4 << (k - 1))) * ((k < 2) ? 480 : 240);
			`CHK("interrupt delay", 1'h1, (n >= e - 40 && n <= e + 40))
			rd_chk(8'h01, {4'h2, 2'(k), 2'(k)});
		end
		// in-window results keep the latched interrupt
		pa = 1'h0;
		repeat (300) @(posedge core_clk);
		`CHK("interrupt held", 1'h0, int_n)
		wr(8'h40, 8'h00);
		`CHK("interrupt cleared", 1'h1, int_n)
		// an in-window result between excursions restarts the count of four
		wr(8'h00, 8'h00);
		wr(8'h40, 8'h00);
		wr(8'h01, 8'h0d);
		pa = 1'h1;
		wr(8'h00, 8'h83);
		repeat (720) @(posedge core_clk);
		#1;
		pa = 1'h0;
		repeat (240) @(posedge core_clk);
		#1;
		pa = 1'h1;
		repeat (720) @(posedge core_clk);
		#1;
		`CHK("interrupt after gap", 1'h1, int_n)
		wait_int();
		`CHK("fourth excursion", 1'h1, (n >= 230 && n <= 250))
		// host-timed span between two restart strobes
		wr(8'h01, 8'h0c);
		wr(8'h00, 8'ha0);
		pa = 1'h1;
		u_host.restart();
		repeat (150) @(posedge core_clk);
		u_host.restart();
		// the span is not known to the tick, so the timer is read and bounded
		u_host.access(1'h0, 8'h06, 8'h00, q);
		res = 16'(q);
		`CHK("host span ticks", 1'h1, (res >= 16'h0009 && res <= 16'h000b))
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h04, res[7:0]);
		u_host.shutdown();
		`CHK("power down", 2'h2, {pd, run})
		close_out();
	end
endmodule : tb

`default_nettype wire
